// file: include/pcfg_consts.svh
// offsets, field positions, reset values and widths of the pad config bank
`ifndef PCFG_CONSTS_SVH
`define PCFG_CONSTS_SVH

`define PCFG_ADDR_W          10
`define PCFG_DATA_W          16
`define PCFG_OFS_MP0_LEVEL   10'h270
`define PCFG_OFS_MP1_LEVEL   10'h271
`define PCFG_OFS_SCLK_PAD    10'h280
`define PCFG_OFS_SOUT_PAD    10'h281
`define PCFG_OFS_SSEL_PAD    10'h282
`define PCFG_OFS_SIN_PAD     10'h283
`define PCFG_OFS_HADDR_PAD   10'h284
`define PCFG_OFS_FAULT_PAD   10'h285
`define PCFG_OFS_FSYNC_PAD   10'h286
`define PCFG_OFS_CTRIG_PAD   10'h287
`define PCFG_PAD_COUNT       8
`define PCFG_PULL_BIT        2
`define PCFG_DRIVE_MSB       1
`define PCFG_DRIVE_LSB       0
`define PCFG_PAD_W           3
`define PCFG_RST_PULLDN      3'h0
`define PCFG_RST_PULLUP      3'h4
`define PCFG_RST_LEVEL       16'h0000
`define PCFG_MODE_PRIMARY    2'h0
`define PCFG_MODE_INPUT      2'h1
`define PCFG_MODE_OUTPUT     2'h2

`endif

// file: include/pcfg_pkg.sv
// types of the pad config bank
package pcfg_pkg;
	typedef enum logic [1:0] {
		PCFG_DRV_LOWEST  = 2'h0,
		PCFG_DRV_LOW     = 2'h1,
		PCFG_DRV_HIGH    = 2'h2,
		PCFG_DRV_HIGHEST = 2'h3
	} pcfg_drive_t;

	typedef enum logic [2:0] {
		PCFG_PAD_SCLK  = 3'h0,
		PCFG_PAD_SOUT  = 3'h1,
		PCFG_PAD_SSEL  = 3'h2,
		PCFG_PAD_SIN   = 3'h3,
		PCFG_PAD_HADDR = 3'h4,
		PCFG_PAD_FAULT = 3'h5,
		PCFG_PAD_FSYNC = 3'h6,
		PCFG_PAD_CTRIG = 3'h7
	} pcfg_pad_t;
endpackage

// file: logic/pcfg_pad_config.sv
// pad control registers and multipurpose pin level readback
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`include "pcfg_consts.svh"

module pcfg_pad_config (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset,
	// register port
	input  wire logic [`PCFG_ADDR_W-1:0]   regAddr,
	input  wire logic [`PCFG_DATA_W-1:0]   regWrData,
	input  wire logic                      regWrEn,
	input  wire logic                      regRdEn,
	output logic      [`PCFG_DATA_W-1:0]   regRdData,
	// multipurpose pins and their function from the mode registers
	input  wire logic                      mpPin0,
	input  wire logic                      mpPin1,
	input  wire logic [1:0]                multipurposePinFunction0,
	input  wire logic [1:0]                multipurposePinFunction1,
	output logic                           mpLevelValid0,
	output logic                           mpLevelValid1,
	// parallel port mode select
	input  wire logic                      parallelPortMode,
	// pad cell controls, one bit or code per pad, index per pcfg_pad_t
	output logic      [`PCFG_PAD_COUNT-1:0] padPullEn,
	output logic      [2*`PCFG_PAD_COUNT-1:0] padDriveCode,
	// parallel data pads sharing settings
	output logic      [1:0]                parallelDataBit6Drive,
	output logic      [1:0]                parallelDataBit7Drive,
	output logic                           parallelDataBit6PullEn,
	output logic                           parallelDataBit7PullEn
);

	// pad register storage
	logic [`PCFG_PAD_W-1:0] padReg_ff [`PCFG_PAD_COUNT];
	// three-stage synchronisers for the two pins
	logic [2:0]             mp0Sync_ff;
	logic [2:0]             mp1Sync_ff;
	logic                   mpLevel0_ff;
	logic                   mpLevel1_ff;
	logic [`PCFG_DATA_W-1:0] nxt_regRdData;
	// levels as they will stand after this edge
	logic                   nxt_mpLevel0;
	logic                   nxt_mpLevel1;
	// decoded register port, shared by the write and read paths
	logic [3:0]             wrIdx;
	logic [3:0]             rdIdx;
	logic [`PCFG_PAD_COUNT-1:0] wrSel;
	logic                   rdLevel0;
	logic                   rdLevel1;

	// decode a pad register offset to its index; valid flag in msb
	function automatic logic [3:0] pad_index(
		input logic [`PCFG_ADDR_W-1:0] addr
	);
		logic [`PCFG_ADDR_W-1:0] diff;
		diff = addr - `PCFG_OFS_SCLK_PAD;
		if (addr >= `PCFG_OFS_SCLK_PAD && addr <= `PCFG_OFS_CTRIG_PAD) begin
			pad_index = {1'b1, diff[2:0]};
		end else begin
			pad_index = 4'h0;
		end
	endfunction

	// reset value of each pad: pull-ups on select, fault and trigger
	function automatic logic [`PCFG_PAD_W-1:0] pad_reset(
		input logic [2:0] idx
	);
		case (idx)
			pcfg_pkg::PCFG_PAD_SSEL:  pad_reset = `PCFG_RST_PULLUP;
			pcfg_pkg::PCFG_PAD_FAULT: pad_reset = `PCFG_RST_PULLUP;
			pcfg_pkg::PCFG_PAD_CTRIG: pad_reset = `PCFG_RST_PULLUP;
			default:                  pad_reset = `PCFG_RST_PULLDN;
		endcase
	endfunction

	// pull enable that a pad comes out of reset with
	function automatic logic pad_pull_reset(
		input logic [2:0] idx
	);
		logic [`PCFG_PAD_W-1:0] rst;
		rst = pad_reset(idx);
		pad_pull_reset = rst[`PCFG_PULL_BIT];
	endfunction

	// pull enable field of a stored pad word
	function automatic logic pull_of(
		input logic [`PCFG_PAD_W-1:0] pad
	);
		pull_of = pad[`PCFG_PULL_BIT];
	endfunction

	// drive code field of a stored pad word
	function automatic logic [1:0] drive_of(
		input logic [`PCFG_PAD_W-1:0] pad
	);
		drive_of = pad[`PCFG_DRIVE_MSB:`PCFG_DRIVE_LSB];
	endfunction

	// a level register word: only bit 0 is backed, the rest read zero
	function automatic logic [`PCFG_DATA_W-1:0] level_word(
		input logic lvl
	);
		level_word    = `PCFG_RST_LEVEL;
		level_word[0] = lvl;
	endfunction

	// a pad register word: bits above the pull enable read zero
	function automatic logic [`PCFG_DATA_W-1:0] pad_word(
		input logic [`PCFG_PAD_W-1:0] pad
	);
		pad_word                  = `PCFG_RST_LEVEL;
		pad_word[`PCFG_PAD_W-1:0] = pad;
	endfunction

	// stages two and three agree: a one-cycle glitch never gets through
	function automatic logic sync_agree(
		input logic [2:0] stages
	);
		sync_agree = stages[1] == stages[2];
	endfunction

	// decode once; a write strobe on an unmapped offset matches nothing
	always_comb begin
		wrIdx = 4'h0;
		if (regWrEn) begin
			wrIdx = pad_index(regAddr);
		end
		rdIdx    = pad_index(regAddr);
		rdLevel0 = regAddr == `PCFG_OFS_MP0_LEVEL;
		rdLevel1 = regAddr == `PCFG_OFS_MP1_LEVEL;
	end

	// one-hot write select, one bit per pad register
	always_comb begin
		wrSel = 8'h00;
		for (int i = 0; i < `PCFG_PAD_COUNT; i++) begin
			wrSel[i] = wrIdx[3] && wrIdx[2:0] == 3'(i);
		end
	end

	// level flops load only when the last two stages agree
	always_comb begin
		nxt_mpLevel0 = mpLevel0_ff;
		nxt_mpLevel1 = mpLevel1_ff;
		if (sync_agree(mp0Sync_ff)) begin
			nxt_mpLevel0 = mp0Sync_ff[2];
		end
		if (sync_agree(mp1Sync_ff)) begin
			nxt_mpLevel1 = mp1Sync_ff[2];
		end
	end

	// pad register writes; bits above 2 are dropped
	always_ff @(posedge clk) begin
		for (int i = 0; i < `PCFG_PAD_COUNT; i++) begin
			if (reset) begin
				padReg_ff[i] <= pad_reset(3'(i));
			end else if (wrSel[i]) begin
				padReg_ff[i] <= regWrData[`PCFG_PAD_W-1:0];
			end
		end
	end

	// the first stage is only read by the second, a change counts once
	// stages two and three agree, filtering a single-cycle glitch
	always_ff @(posedge clk) begin
		if (reset) begin
			mp0Sync_ff <= 3'h0;
		end else begin
			mp0Sync_ff <= {mp0Sync_ff[1:0], mpPin0};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mp1Sync_ff <= 3'h0;
		end else begin
			mp1Sync_ff <= {mp1Sync_ff[1:0], mpPin1};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mpLevel0_ff <= 1'b0;
		end else begin
			mpLevel0_ff <= nxt_mpLevel0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mpLevel1_ff <= 1'b0;
		end else begin
			mpLevel1_ff <= nxt_mpLevel1;
		end
	end

	// level is shown regardless of function; the valid flag tells when
	// it means anything, so software in output mode sees its own pin
	always_ff @(posedge clk) begin
		if (reset) begin
			mpLevelValid0 <= 1'b0;
		end else begin
			mpLevelValid0 <= multipurposePinFunction0 == `PCFG_MODE_INPUT;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mpLevelValid1 <= 1'b0;
		end else begin
			mpLevelValid1 <= multipurposePinFunction1 == `PCFG_MODE_INPUT;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		nxt_regRdData = `PCFG_RST_LEVEL;
		if (rdLevel0) begin
			nxt_regRdData = level_word(mpLevel0_ff);
		end else if (rdLevel1) begin
			nxt_regRdData = level_word(mpLevel1_ff);
		end else if (rdIdx[3]) begin
			nxt_regRdData = pad_word(padReg_ff[rdIdx[2:0]]);
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			regRdData <= `PCFG_RST_LEVEL;
		end else if (regRdEn) begin
			regRdData <= nxt_regRdData;
		end else begin
			regRdData <= `PCFG_RST_LEVEL;
		end
	end

	// pad outputs, registered copies of the pad registers
	always_ff @(posedge clk) begin
		for (int i = 0; i < `PCFG_PAD_COUNT; i++) begin
			if (reset) begin
				padPullEn[i] <= pad_pull_reset(3'(i));
			end else begin
				padPullEn[i] <= pull_of(padReg_ff[i]);
			end
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < `PCFG_PAD_COUNT; i++) begin
			if (reset) begin
				padDriveCode[2*i +: 2] <= 2'h0;
			end else begin
				padDriveCode[2*i +: 2] <= drive_of(padReg_ff[i]);
			end
		end
	end

	// parallel data bits 6 and 7 borrow the address and frame sync pads;
	// outside parallel mode they sit at the lowest drive, no pull
	always_ff @(posedge clk) begin
		if (reset || !parallelPortMode) begin
			parallelDataBit6Drive <= 2'h0;
			parallelDataBit7Drive <= 2'h0;
		end else begin
			parallelDataBit6Drive <=
				drive_of(padReg_ff[pcfg_pkg::PCFG_PAD_HADDR]);
			parallelDataBit7Drive <=
				drive_of(padReg_ff[pcfg_pkg::PCFG_PAD_FSYNC]);
		end
	end

	// sharing the pull as well keeps the data bits from floating
	always_ff @(posedge clk) begin
		if (reset || !parallelPortMode) begin
			parallelDataBit6PullEn <= 1'b0;
			parallelDataBit7PullEn <= 1'b0;
		end else begin
			parallelDataBit6PullEn <=
				pull_of(padReg_ff[pcfg_pkg::PCFG_PAD_HADDR]);
			parallelDataBit7PullEn <=
				pull_of(padReg_ff[pcfg_pkg::PCFG_PAD_FSYNC]);
		end
	end

endmodule // pcfg_pad_config

// file: sim/pcfg_properties.sv
// port checker of the pad config bank
`timescale 1ns/10ps
module pcfg_checker (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// register port
	input wire logic [9:0]  regAddr,
	input wire logic [15:0] regWrData,
	input wire logic        regWrEn,
	input wire logic        regRdEn,
	input wire logic [15:0] regRdData,
	// pins and pads
	input wire logic [1:0]  multipurposePinFunction0,
	input wire logic        mpLevelValid0,
	input wire logic        parallelPortMode,
	input wire logic [7:0]  padPullEn,
	input wire logic [15:0] padDriveCode,
	input wire logic [1:0]  parallelDataBit6Drive,
	input wire logic [1:0]  parallelDataBit7Drive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_rd_idle;
		!$past(regRdEn) |-> regRdData == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_lvl;
		regRdEn && regAddr[9:1] == 9'h138 |=> regRdData[15:1] == 15'h0000;
	endproperty
	a_lvl: assert property (p_lvl) else $error("level upper bits set");
	property p_wr_pad;
		regWrEn && regAddr[9:3] == 7'h50 |-> ##2
		{padPullEn[$past(regAddr[2:0], 2)],
		padDriveCode[2*$past(regAddr[2:0], 2)+:2]} == $past(regWrData[2:0], 2);
	endproperty
	a_wr_pad: assert property (p_wr_pad) else $error("pad output wrong");
	property p_rst;
		$past(reset) |-> padPullEn == 8'hA4 && padDriveCode == 16'h0000;
	endproperty
	a_rst: assert property (p_rst) else $error("pad reset wrong");
	property p_par_off;
		!parallelPortMode && !$past(parallelPortMode) |->
		parallelDataBit6Drive == 2'h0 && parallelDataBit7Drive == 2'h0;
	endproperty
	a_par_off: assert property (p_par_off) else $error("parallel drive on");
	property p_par6;
		parallelPortMode && $past(parallelPortMode) && $stable(padDriveCode)
		|-> parallelDataBit6Drive == padDriveCode[9:8];
	endproperty
	a_par6: assert property (p_par6) else $error("bit6 drive wrong");
	property p_par7;
		parallelPortMode && $past(parallelPortMode) && $stable(padDriveCode)
		|-> parallelDataBit7Drive == padDriveCode[13:12];
	endproperty
	a_par7: assert property (p_par7) else $error("bit7 drive wrong");
	property p_valid;
		!$past(reset) |-> mpLevelValid0 == ($past(multipurposePinFunction0) == 2'h1);
	endproperty
	a_valid: assert property (p_valid) else $error("level valid wrong");
endmodule // pcfg_checker

bind pcfg_pad_config pcfg_checker u_checker (.clk, .reset, .regAddr, .regWrData,
	.regWrEn, .regRdEn, .regRdData, .multipurposePinFunction0, .mpLevelValid0,
	.parallelPortMode, .padPullEn, .padDriveCode, .parallelDataBit6Drive,
	.parallelDataBit7Drive);

// file: sim/pcfg_pad_config_bench.sv
// self-checking bench of the pad config bank
`timescale 1ns/10ps
module pcfg_pad_config_bench;
	logic        clk = 0, reset = 1, regWrEn = 0, regRdEn = 0;
	logic [9:0]  regAddr = 0;
	logic [15:0] regWrData = 0, regRdData, padDriveCode;
	logic        mpPin0 = 0, mpPin1 = 0, parallelPortMode = 0;
	logic [1:0]  multipurposePinFunction0 = 0, multipurposePinFunction1 = 0;
	logic        mpLevelValid0, mpLevelValid1;
	logic [7:0]  padPullEn;
	logic [1:0]  parallelDataBit6Drive, parallelDataBit7Drive;
	logic        parallelDataBit6PullEn, parallelDataBit7PullEn;
	int          errors = 0, check_count = 0, cyc = 0;
	pcfg_pad_config u_dut (.clk, .reset, .regAddr, .regWrData, .regWrEn,
		.regRdEn, .regRdData, .mpPin0, .mpPin1, .multipurposePinFunction0,
		.multipurposePinFunction1, .mpLevelValid0, .mpLevelValid1,
		.parallelPortMode, .padPullEn, .padDriveCode, .parallelDataBit6Drive,
		.parallelDataBit7Drive, .parallelDataBit6PullEn,
		.parallelDataBit7PullEn);
	always #2 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask
	// read data stand one cycle only, so sample just after the answer edge
	task automatic rd(input logic [9:0] a, input logic [15:0] exp);
		@(posedge clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1 chk(regRdData, exp);
	endtask
	task automatic t_reset;
		chk({8'h0, padPullEn}, 16'h00A4);
		chk(padDriveCode, 16'h0000);
		for (int i = 0; i < 8; i++)
			rd(10'h280 + 10'(i), {13'h0, i == 2 || i >= 5 && i != 6, 2'h0});
		rd(10'h270, 16'h0000);
		rd(10'h271, 16'h0000);
	endtask
	// upper ones must be dropped; drive codes walk all four values
	task automatic t_rw;
		for (int i = 0; i < 8; i++) begin
			wr(10'h280 + 10'(i), 16'hFFF8 | 16'(i));
			rd(10'h280 + 10'(i), 16'(i));
		end
		repeat (2) @(posedge clk);
		chk({8'h0, padPullEn}, 16'h00F0);
		chk(padDriveCode, 16'hE4E4);
	endtask
	task automatic t_ro;
		wr(10'h270, 16'hFFFF);
		rd(10'h270, 16'h0000);
		wr(10'h2A0, 16'hFFFF);
		rd(10'h2A0, 16'h0000);
		@(posedge clk);
		chk({8'h0, padPullEn}, 16'h00F0);
	endtask
	task automatic t_pin;
		@(posedge clk);
		mpPin0 <= 1'b1;
		multipurposePinFunction0 <= 2'h1;
		multipurposePinFunction1 <= 2'h2;
		repeat (6) @(posedge clk);
		rd(10'h270, 16'h0001);
		rd(10'h271, 16'h0000);
		chk({14'h0, mpLevelValid1, mpLevelValid0}, 16'h0001);
		@(posedge clk);
		mpPin1 <= 1'b1;
		repeat (6) @(posedge clk);
		rd(10'h271, 16'h0001);
		@(posedge clk);
		multipurposePinFunction0 <= 2'h0;
		repeat (2) @(posedge clk);
		chk({15'h0, mpLevelValid0}, 16'h0000);
	endtask
	task automatic t_par;
		@(posedge clk);
		parallelPortMode <= 1'b1;
		wr(10'h284, 16'h0007);
		repeat (3) @(posedge clk);
		chk({10'h0, parallelDataBit7PullEn, parallelDataBit6PullEn,
			parallelDataBit7Drive, parallelDataBit6Drive}, 16'h003B);
		parallelPortMode <= 1'b0;
		repeat (3) @(posedge clk);
		chk({12'h0, parallelDataBit7Drive, parallelDataBit6Drive}, 16'h0);
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// the whole run needs some one hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			print_verdict;
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_reset;
		t_rw;
		t_ro;
		t_pin;
		t_par;
		print_verdict;
	end
endmodule // pcfg_pad_config_bench
